// ---- src/sfr_pkg.sv ----
// constants shared by the serial flash read front end
package sfr_pkg;
  localparam logic [7:0]  SFR_CMD_PLAIN_READ  = 8'h03;
  localparam logic [7:0]  SFR_CMD_FAST_READ   = 8'h0B;
  localparam logic [7:0]  SFR_CMD_SET_PARAMS  = 8'hC0;
  localparam logic [7:0]  SFR_CMD_SUSPEND     = 8'h75;
  localparam logic [7:0]  SFR_CMD_RESUME      = 8'h7A;
  localparam logic [7:0]  SFR_CMD_UNIQUE_ID   = 8'h4B;
  localparam logic [7:0]  SFR_CMD_QUAD_ENTER  = 8'h38;
  localparam logic [7:0]  SFR_CMD_QUAD_EXIT   = 8'hFF;
  localparam int          SFR_ADDR_W          = 22;
  localparam int          SFR_TOP_VALID_BIT   = 21;
  localparam logic [21:0] SFR_ADDR_ZERO       = 22'h000000;
  localparam logic [21:0] SFR_ADDR_TOP        = 22'h3FFFFF;
  localparam logic [21:0] SFR_UID_ADDR_MASK   = 22'h0001FF;
  localparam logic [3:0]  SFR_DUMMY_DEFAULT   = 4'h4;
  localparam logic [1:0]  SFR_PARAM_DUMMY_LSB = 2'h0;
  localparam logic [5:0]  SFR_BITS_CMD_SINGLE = 6'h08;
  localparam logic [5:0]  SFR_BITS_ADDR_SINGLE = 6'h18;
  localparam logic [5:0]  SFR_BITS_DUMMY_SINGLE = 6'h08;
  localparam logic [5:0]  SFR_CLKS_CMD_QUAD   = 6'h02;
  localparam logic [5:0]  SFR_CLKS_ADDR_QUAD  = 6'h06;
  localparam logic [3:0]  SFR_NIBBLES_PARAM   = 4'h2;
  localparam logic [3:0]  SFR_BIT_TOP         = 4'h7;
  localparam logic [3:0]  SFR_NIB_TOP         = 4'h1;
  typedef enum logic [5:0] {
    SFR_ST_CMD   = 6'b000001,
    SFR_ST_ADDR  = 6'b000010,
    SFR_ST_DUMMY = 6'b000100,
    SFR_ST_DATA  = 6'b001000,
    SFR_ST_PARAM = 6'b010000,
    SFR_ST_IDLE  = 6'b100000
  } sfr_state_t;
endpackage : sfr_pkg

// ---- src/sfr_sync.sv ----
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sfr_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : sfr_sync
`default_nettype wire

// ---- src/sfr_front_end.sv ----
// serial flash read front end: command decode, pause, read data paths
`timescale 1ns/1ps
`default_nettype none
// Operation
// - set-params command loads quad dummy count
// - mode byte clocks count within dummy
// - unique id read ignores high address
// - pause low freezes sequence state
// - pause release resumes, clocks ignored
// - paused: output hi-z, input ignored
// - pause off under dtr, quad, reset
// - plain read: command, 24 address bits
// - decode address bits 21 to 0 only
// - input ignored after plain read address
// - data msb first, address increments
// - address wraps to zero at top
// - chip select high ends read
// - reads discarded while write in progress
// - fast read has one dummy byte in single mode, dummy_q clocks in quad
// - sample rising edge, drive falling edge
// - quad: 2 command, 6 address clocks
// - quad data one nibble per clock
// - decode suspend command byte
// - decode resume command byte
// - msb first, command byte opens sequence
// - dtr latches on both edges (not done here: dtr_mode only disables pause)
module sfr_front_end
  import sfr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       pause_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  input  wire logic       write_in_progress,
  input  wire logic       quad_enable,
  input  wire logic       dtr_mode,
  input  wire logic       pin_is_reset,
  output logic [21:0]     array_addr,
  input  wire logic [7:0] array_data,
  output logic            quad_command_mode,
  output logic [3:0]      dummy_clocks,
  output logic            suspend_req,
  output logic            resume_req,
  output logic            read_active
);
  ////////////////////////////////////////////////////////////////////
  // link domain, clocked by sck; chip select high resets all of it except the event toggles, dummy_q and the input synchronisers
  sfr_state_t  state;
  logic [7:0]  cmd;
  logic [5:0]  cnt;
  logic [21:0] addr;
  logic [7:0]  shreg;
  logic [7:0]  param;
  logic        is_fast;
  logic        paused;
  logic        quad_q;
  logic [3:0]  dummy_q;
  logic        susp_tgl;
  logic        res_tgl;
  logic        quad_set_tgl;
  logic        quad_clr_tgl;
  logic        param_tgl;
  logic        wip_s;
  logic        quad_en_s;
  logic        dtr_s;
  logic        rstpin_s;
  logic        pause_ok;
  logic [7:0]  next_cmd;
  logic [7:0]  data_q;
  logic [3:0]  bitpos;

  sfr_sync u_wip_sck  (.clk(sck), .rst(reset), .d(write_in_progress), .q(wip_s));
  sfr_sync u_qen_sck  (.clk(sck), .rst(reset), .d(quad_enable),       .q(quad_en_s));
  sfr_sync u_dtr_sck  (.clk(sck), .rst(reset), .d(dtr_mode),          .q(dtr_s));
  sfr_sync u_rpin_sck (.clk(sck), .rst(reset), .d(pin_is_reset),      .q(rstpin_s));
  sfr_sync u_quad_sck (.clk(sck), .rst(reset), .d(quad_command_mode), .q(quad_q));

  assign pause_ok = !(dtr_s || quad_en_s || rstpin_s);

  // pin changes only while sck low, so both edges see a settled level
  assign paused = pause_ok && !pause_n;

  // dummy count mirrored in the link domain
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      dummy_q <= SFR_DUMMY_DEFAULT;
    end else begin
      dummy_q <= dummy_clocks;
    end
  end

  always_comb begin
    if (quad_q) begin
      next_cmd = {shreg[3:0], io_in};
    end else begin
      next_cmd = {shreg[6:0], io_in[0]};
    end
  end

  // command, address and dummy sampled on rising edge
  always_ff @(posedge sck or posedge reset or posedge cs_n) begin
    if (reset || cs_n) begin
      state   <= SFR_ST_CMD;
      cnt     <= 6'h00;
      cmd     <= 8'h00;
      shreg   <= 8'h00;
      addr    <= SFR_ADDR_ZERO;
      is_fast <= 1'b0;
      param   <= 8'h00;
    end else if (!paused) begin
      case (state)
        SFR_ST_CMD: begin
          shreg <= next_cmd;
          cnt   <= cnt + 6'h01;
          if ((quad_q && cnt == SFR_CLKS_CMD_QUAD - 6'h01)
              || (!quad_q && cnt == SFR_BITS_CMD_SINGLE - 6'h01)) begin
            cmd <= next_cmd;
            cnt <= 6'h00;
            if ((next_cmd == SFR_CMD_PLAIN_READ && !quad_q)
                || next_cmd == SFR_CMD_FAST_READ
                || next_cmd == SFR_CMD_UNIQUE_ID) begin
              if (wip_s) begin
                state <= SFR_ST_IDLE;
              end else begin
                state   <= SFR_ST_ADDR;
                is_fast <= (next_cmd != SFR_CMD_PLAIN_READ);
              end
            end else if (next_cmd == SFR_CMD_SET_PARAMS && quad_q) begin
              state <= SFR_ST_PARAM;
            end else begin
              state <= SFR_ST_IDLE;
            end
          end
        end
        SFR_ST_ADDR: begin
          cnt <= cnt + 6'h01;
          if (quad_q) begin
            addr <= {addr[17:0], io_in};
          end else begin
            addr <= {addr[20:0], io_in[0]};
          end
          if ((quad_q && cnt == SFR_CLKS_ADDR_QUAD - 6'h01)
              || (!quad_q && cnt == SFR_BITS_ADDR_SINGLE - 6'h01)) begin
            cnt   <= 6'h00;
            state <= is_fast ? SFR_ST_DUMMY : SFR_ST_DATA;
          end
        end
        SFR_ST_DUMMY: begin
          // mode byte clocks, if any, sit inside this count
          cnt <= cnt + 6'h01;
          if ((quad_q && cnt == {2'b00, dummy_q} - 6'h01)
              || (!quad_q && cnt == SFR_BITS_DUMMY_SINGLE - 6'h01)) begin
            cnt   <= 6'h00;
            state <= SFR_ST_DATA;
          end
        end
        SFR_ST_PARAM: begin
          shreg <= next_cmd;
          cnt   <= cnt + 6'h01;
          if (cnt == {2'b00, SFR_NIBBLES_PARAM} - 6'h01) begin
            param <= next_cmd;
            state <= SFR_ST_IDLE;
          end
        end
        SFR_ST_DATA: begin
          state <= SFR_ST_DATA;
        end
        SFR_ST_IDLE: begin
          state <= SFR_ST_IDLE;
        end
        default: begin
          state <= SFR_ST_IDLE;
        end
      endcase
    end
  end

  // event toggles at end of command byte
  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      susp_tgl     <= 1'b0;
      res_tgl      <= 1'b0;
      quad_set_tgl <= 1'b0;
      quad_clr_tgl <= 1'b0;
    end else if (!cs_n && !paused && state == SFR_ST_CMD
                 && ((quad_q && cnt == SFR_CLKS_CMD_QUAD - 6'h01)
                     || (!quad_q && cnt == SFR_BITS_CMD_SINGLE - 6'h01))) begin
      if (next_cmd == SFR_CMD_SUSPEND) begin
        susp_tgl <= ~susp_tgl;
      end
      if (next_cmd == SFR_CMD_RESUME) begin
        res_tgl <= ~res_tgl;
      end
      if (next_cmd == SFR_CMD_QUAD_ENTER && !quad_q) begin
        quad_set_tgl <= ~quad_set_tgl;
      end
      if (next_cmd == SFR_CMD_QUAD_EXIT && quad_q) begin
        quad_clr_tgl <= ~quad_clr_tgl;
      end
    end
  end

  always_ff @(posedge sck or posedge reset) begin
    if (reset) begin
      param_tgl <= 1'b0;
    end else if (!cs_n && !paused && state == SFR_ST_PARAM
                 && cnt == {2'b00, SFR_NIBBLES_PARAM} - 6'h01) begin
      param_tgl <= ~param_tgl;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // data output on falling edge
  logic [21:0] rd_addr;
  logic        out_en;
  logic        step_tgl;

  always_ff @(negedge sck or posedge reset or posedge cs_n) begin
    if (reset || cs_n) begin
      bitpos  <= 4'h0;
      rd_addr <= SFR_ADDR_ZERO;
      data_q  <= 8'h00;
      out_en  <= 1'b0;
      io_out  <= 4'h0;
      step_tgl <= 1'b0;
    end else if (paused) begin
      out_en <= out_en;
    end else if (state == SFR_ST_DATA) begin
      out_en <= 1'b1;
      if (bitpos == 4'h0) begin
        data_q <= array_data;
        if (cmd == SFR_CMD_UNIQUE_ID) begin
          rd_addr <= addr & SFR_UID_ADDR_MASK;
        end else begin
          rd_addr <= addr;
        end
      end
      if (quad_q) begin
        io_out <= (bitpos == 4'h0) ? array_data[7:4] : data_q[3:0];
        if (bitpos == SFR_NIB_TOP) begin
          bitpos <= 4'h0;
          step_tgl <= ~step_tgl;
        end else begin
          bitpos <= bitpos + 4'h1;
        end
      end else begin
        io_out <= {2'b00, ((bitpos == 4'h0) ? array_data[7] : data_q[3'(~bitpos[2:0])]), 1'b0};
        if (bitpos == SFR_BIT_TOP) begin
          bitpos <= 4'h0;
          step_tgl <= ~step_tgl;
        end else begin
          bitpos <= bitpos + 4'h1;
        end
      end
    end
  end

  // address source for the array: follows address bits as they arrive,
  // so the first byte is valid at the first output edge; wraps at the top
  logic [21:0] cur_addr;
  logic [21:0] next_addr;
  logic        step_seen;
  always_comb begin
    if (quad_q) begin
      next_addr = {addr[17:0], io_in};
    end else begin
      next_addr = {addr[20:0], io_in[0]};
    end
  end

  always_ff @(posedge sck or posedge reset or posedge cs_n) begin
    if (reset || cs_n) begin
      cur_addr  <= SFR_ADDR_ZERO;
      step_seen <= 1'b0;
    end else if (step_tgl != step_seen) begin
      step_seen <= step_tgl;
      cur_addr <= (cur_addr == SFR_ADDR_TOP) ? SFR_ADDR_ZERO : cur_addr + 22'h000001;
    end else if (!paused && state == SFR_ST_ADDR) begin
      cur_addr <= (cmd == SFR_CMD_UNIQUE_ID) ? (next_addr & SFR_UID_ADDR_MASK)
                                             : next_addr;
    end
  end

  always_comb begin
    if (!out_en || cs_n || paused) begin
      io_oe = 4'h0;
    end else if (quad_q) begin
      io_oe = 4'hF;
    end else begin
      io_oe = 4'h2;
    end
  end

  assign array_addr = cur_addr;

  ////////////////////////////////////////////////////////////////////
  // system domain: flags and pulses from link toggles
  logic susp_s, res_s, qset_s, qclr_s, par_s, act_s;
  logic susp_d, res_d, qset_d, qclr_d, par_d;

  sfr_sync u_susp (.clk(sys_clk), .rst(reset), .d(susp_tgl),     .q(susp_s));
  sfr_sync u_res  (.clk(sys_clk), .rst(reset), .d(res_tgl),      .q(res_s));
  sfr_sync u_qset (.clk(sys_clk), .rst(reset), .d(quad_set_tgl), .q(qset_s));
  sfr_sync u_qclr (.clk(sys_clk), .rst(reset), .d(quad_clr_tgl), .q(qclr_s));
  sfr_sync u_par  (.clk(sys_clk), .rst(reset), .d(param_tgl),    .q(par_s));
  sfr_sync u_act  (.clk(sys_clk), .rst(reset), .d(out_en),       .q(act_s));

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      susp_d <= 1'b0;
      res_d  <= 1'b0;
      qset_d <= 1'b0;
      qclr_d <= 1'b0;
      par_d  <= 1'b0;
    end else begin
      susp_d <= susp_s;
      res_d  <= res_s;
      qset_d <= qset_s;
      qclr_d <= qclr_s;
      par_d  <= par_s;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      suspend_req <= 1'b0;
      resume_req  <= 1'b0;
      read_active <= 1'b0;
    end else begin
      suspend_req <= susp_s ^ susp_d;
      resume_req  <= res_s ^ res_d;
      read_active <= act_s;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      quad_command_mode <= 1'b0;
    end else if (qset_s ^ qset_d) begin
      quad_command_mode <= 1'b1;
    end else if (qclr_s ^ qclr_d) begin
      quad_command_mode <= 1'b0;
    end
  end

  // param byte is loaded on the same sck edge as its toggle, so it is settled when the toggle lands
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dummy_clocks <= SFR_DUMMY_DEFAULT;
    end else if (par_s ^ par_d) begin
      dummy_clocks <= param[3:0];
    end
  end

endmodule : sfr_front_end
`default_nettype wire

// ---- tb/sfr_front_end_properties.sv ----
// port assertions for the serial flash read front end
`timescale 1ns/1ps
`default_nettype none
module sfr_front_end_properties
  import sfr_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        pause_n,
  input wire logic [3:0]  io_oe,
  input wire logic        write_in_progress,
  input wire logic        quad_enable,
  input wire logic        dtr_mode,
  input wire logic        pin_is_reset,
  input wire logic [21:0] array_addr,
  input wire logic        quad_command_mode,
  input wire logic [3:0]  dummy_clocks,
  input wire logic        suspend_req,
  input wire logic        resume_req,
  input wire logic        read_active
);
  property p_idle_hiz;
    @(posedge sys_clk) disable iff (reset) cs_n && $past(cs_n) |-> io_oe == 4'h0;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("oe while deselected");
  property p_lane_width;
    @(posedge sys_clk) disable iff (reset)
      io_oe != 4'h0 |-> io_oe == (quad_command_mode ? 4'hF : 4'h2);
  endproperty
  a_lane_width: assert property (p_lane_width) else $error("wrong lanes");
  property p_suspend_pulse;
    @(posedge sys_clk) disable iff (reset) suspend_req |=> !suspend_req;
  endproperty
  a_suspend_pulse: assert property (p_suspend_pulse) else $error("long suspend");
  property p_resume_pulse;
    @(posedge sys_clk) disable iff (reset) resume_req |-> !suspend_req ##1 !resume_req;
  endproperty
  a_resume_pulse: assert property (p_resume_pulse) else $error("bad resume");
  property p_dummy_quad;
    @(posedge sys_clk) disable iff (reset) $changed(dummy_clocks) |-> quad_command_mode;
  endproperty
  a_dummy_quad: assert property (p_dummy_quad) else $error("dummy load");
  property p_busy_quiet;
    @(negedge sck) disable iff (reset) write_in_progress |-> io_oe == 4'h0;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy read drove");
  property p_pause_hiz;
    @(posedge sck) disable iff (reset)
      !pause_n && !$past(pause_n) && !(quad_enable || dtr_mode || pin_is_reset)
      |-> io_oe == 4'h0;
  endproperty
  a_pause_hiz: assert property (p_pause_hiz) else $error("paused but driving");
  property p_active_ends;
    @(posedge sys_clk) disable iff (reset) cs_n [*6] |-> !read_active;
  endproperty
  a_active_ends: assert property (p_active_ends) else $error("active stuck");
  property p_addr_step;
    @(negedge sck) disable iff (reset)
      io_oe != 4'h0 && $past(io_oe) != 4'h0 && $changed(array_addr)
      |-> array_addr == 22'($past(array_addr) + 22'h000001);
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("bad address step");
  c_suspend: cover property (@(posedge sys_clk) suspend_req);
  c_resume: cover property (@(posedge sys_clk) resume_req);
  c_quad_data: cover property (@(negedge sck) io_oe == 4'hF);
endmodule : sfr_front_end_properties
bind sfr_front_end sfr_front_end_properties u_props (.sys_clk, .reset, .sck, .cs_n,
  .pause_n, .io_oe, .write_in_progress, .quad_enable, .dtr_mode, .pin_is_reset,
  .array_addr, .quad_command_mode, .dummy_clocks, .suspend_req, .resume_req, .read_active);
`default_nettype wire

// ---- tb/sfr_host_model.sv ----
// behavioural spi host driving the link
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model (
  output logic           sck,
  output logic           cs_n,
  output logic           pause_n,
  output logic     [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  logic       q = 1'b0;
  logic [3:0] seen = 4'h0;
  logic [3:0] po = 4'h0;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    pause_n = 1'b1;
    io_in = 4'h0;
  end
  task automatic rpulse();
    #5 sck = 1'b1;
    #5 sck = 1'b0;
  endtask : rpulse
  task automatic tick(); // 6.25 MHz link
    #80 sck = 1'b1;
    #80 sck = 1'b0;
  endtask : tick
  // released lines toggle so stale values never look valid
  task automatic dum(input int n);
    repeat (n) begin
      io_in = ~io_in;
      tick();
    end
  endtask : dum
  task automatic sb(input logic [7:0] b);
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      if (q) io_in = (i == 0) ? b[7:4] : b[3:0];
      else io_in[0] = b[7 - i];
      tick();
    end
  endtask : sb
  task automatic rx(input int n, inout logic [7:0] v);
    repeat (n) begin
      io_in = ~io_in;
      #80 v = q ? {v[3:0], io_out} : {v[6:0], io_out[1]};
      seen = seen | io_oe;
      sck = 1'b1;
      #80 sck = 1'b0;
    end
  endtask : rx
  task automatic hold(input int n); // pause set and cleared with sck low
    pause_n = 1'b0;
    dum(n);
    #40 po = io_oe;
    pause_n = 1'b1;
  endtask : hold
  task automatic go();
    #87 cs_n = 1'b0;
    seen = 4'h0;
  endtask : go
  // two idle clocks let link-side synchronisers see new flags
  task automatic stop();
    #80 cs_n = 1'b1;
    io_in = ~io_in;
    tick();
    tick();
  endtask : stop
endmodule : sfr_host_model
`default_nettype wire

// ---- tb/test_sfr_front_end.sv ----
// self-checking bench for the serial flash read front end
`timescale 1ns/1ps
`default_nettype none
module test_sfr_front_end import sfr_pkg::*; ;
  logic        sys_clk;
  logic        reset;
  logic        write_in_progress;
  logic        quad_enable;
  logic        dtr_mode;
  logic        pin_is_reset;
  logic        read_active;
  logic        sck;
  logic        cs_n;
  logic        pause_n;
  logic [3:0]  host_io;
  logic [3:0]  io_w;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic [21:0] array_addr;
  logic [7:0]  array_data;
  logic        quad_command_mode;
  logic [3:0]  dummy_clocks;
  logic        suspend_req;
  logic        resume_req;
  logic [7:0]  v;
  logic [15:0] w;
  int          errors = 0;
  int          n_tests = 0;
  int          n_sus = 0;
  int          n_res = 0;
  function automatic logic [7:0] f(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
  endfunction : f
  assign array_data = f(array_addr);
  assign io_w = (io_oe & io_out) | (~io_oe & host_io);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (suspend_req === 1'b1) n_sus++;
    if (resume_req === 1'b1) n_res++;
  end
  initial begin
    #500000;
    errors++;
    summarize();
  end
  sfr_host_model hm (.sck, .cs_n, .pause_n, .io_in(host_io), .io_out, .io_oe);
  sfr_front_end u_dut (.sys_clk, .reset, .sck, .cs_n, .pause_n, .io_in(io_w), .io_out,
    .io_oe, .write_in_progress, .quad_enable, .dtr_mode, .pin_is_reset,
    .array_addr, .array_data, .quad_command_mode, .dummy_clocks, .suspend_req,
    .resume_req, .read_active);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic cmd(input logic [7:0] c, input logic [23:0] a, input int nd);
    hm.go();
    hm.sb(c);
    hm.sb(a[23:16]);
    hm.sb(a[15:8]);
    hm.sb(a[7:0]);
    hm.dum(nd);
  endtask : cmd
  task automatic endt(input string s);
    hm.stop();
    $display("%s done", s);
  endtask : endt
  task automatic op(input logic [7:0] c);
    hm.go();
    hm.sb(c);
    endt("command");
  endtask : op
  initial begin
    reset = 1'b1;
    write_in_progress = 1'b0;
    quad_enable = 1'b0;
    dtr_mode = 1'b0;
    pin_is_reset = 1'b0;
    v = 8'h00;
    repeat (2) hm.rpulse();
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    hm.dum(2);
    chk(8'(dummy_clocks), 8'(SFR_DUMMY_DEFAULT));
    chk(8'(io_oe), 8'h00);
    endt("reset");
    cmd(SFR_CMD_PLAIN_READ, 24'hC12345, 0);
    hm.rx(8, v);
    chk(v, f(22'h012345));
    chk(8'(read_active), 8'h01);
    hm.rx(8, v);
    chk(v, f(22'h012346));
    endt("plain read");
    chk(8'(read_active), 8'h00);
    cmd(SFR_CMD_FAST_READ, 24'h3FFFFF, 8);
    hm.rx(8, v);
    chk(v, f(SFR_ADDR_TOP));
    hm.rx(8, v);
    chk(v, f(SFR_ADDR_ZERO));
    endt("fast read wrap");
    cmd(SFR_CMD_UNIQUE_ID, 24'hABCC0F, 8);
    hm.rx(8, v);
    chk(v, f(22'h00000F));
    endt("unique id");
    @(negedge sys_clk) write_in_progress = 1'b1;
    cmd(SFR_CMD_PLAIN_READ, 24'h000010, 0);
    hm.rx(8, v);
    chk(8'(hm.seen), 8'h00);
    endt("busy read");
    @(negedge sys_clk) write_in_progress = 1'b0;
    cmd(SFR_CMD_PLAIN_READ, 24'h000020, 0);
    hm.rx(4, v);
    hm.hold(3);
    hm.rx(4, v);
    chk(v, f(22'h000020));
    chk(8'(hm.po), 8'h00);
    endt("pause");
    w = {f(22'h000030), f(22'h000031)};
    for (int k = 0; k < 3; k++) begin
      @(negedge sys_clk) {quad_enable, dtr_mode, pin_is_reset} = 3'(3'h4 >> k);
      cmd(SFR_CMD_PLAIN_READ, 24'h000030, 0);
      hm.rx(4, v);
      hm.hold(2);
      hm.rx(4, v);
      chk(v, {w[15:12], w[9:6]});
      endt("pause disabled");
    end
    @(negedge sys_clk) {quad_enable, dtr_mode, pin_is_reset} = 3'h0;
    op(SFR_CMD_SUSPEND);
    op(SFR_CMD_RESUME);
    op(SFR_CMD_QUAD_ENTER);
    hm.q = 1'b1;
    chk(8'(quad_command_mode), 8'h01);
    hm.go();
    hm.sb(SFR_CMD_SET_PARAMS);
    hm.sb(8'h06);
    endt("set params");
    chk(8'(dummy_clocks), 8'h06);
    cmd(SFR_CMD_FAST_READ, 24'h00ABCD, 6);
    hm.rx(2, v);
    chk(v, f(22'h00ABCD));
    hm.rx(2, v);
    chk(v, f(22'h00ABCE));
    endt("quad read");
    op(SFR_CMD_SUSPEND);
    op(SFR_CMD_RESUME);
    chk(8'(n_sus), 8'h02);
    chk(8'(n_res), 8'h02);
    op(SFR_CMD_QUAD_EXIT);
    hm.q = 1'b0;
    chk(8'(quad_command_mode), 8'h00);
    summarize();
  end
endmodule : test_sfr_front_end
`default_nettype wire
